// [spg_delay_timer.sv]
`timescale 1ns/1ns
module spg_delay_timer
  import spg_pkg::*;
#(
  parameter int CNT_W = SPG_CNT_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // load a count, done pulses when it expires
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  output logic running,
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic done;
  } spg_tmr_s;

  spg_tmr_s st_reg;
  spg_tmr_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load)
    begin
      st_next.cnt = count;
      st_next.run = 1'b1;
    end
    else if (st_reg.run)
    begin
      if (st_reg.cnt <= CNT_W'(1))
      begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
        st_next.cnt = '0;
      end
      else
        st_next.cnt = st_reg.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign running = st_reg.run;
  assign done = st_reg.done;
endmodule : spg_delay_timer

// [spg_edge_sync.sv]
`timescale 1ns/1ns
module spg_edge_sync
  import spg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // async level in, synchronised level and rising edge out
  input wire logic din,
  output logic dout,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } spg_sync_s;

  spg_sync_s st_reg;
  spg_sync_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign dout = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
endmodule : spg_edge_sync

// [spg_guard_monitor.sv]
`timescale 1ns/1ns
module spg_guard_monitor
  import spg_pkg::*;
#(
  parameter int SECTORS = 256,
  parameter int FAIL_CYCLES = SPG_FAIL_CYCLES,
  parameter int OP_CYCLES = SPG_OP_CYCLES
)
(
  // clock, reset and requests
  input wire logic clk,
  input wire logic nrst,
  input wire logic hw_reset_n,
  input wire logic req_valid,
  input wire spg_req_s req,
  input wire logic read_protect,
  // answers
  input wire spg_rsp_s rsp,
  input wire logic [SECTORS-1:0] sector_protected,
  input wire logic [7:0] rd_sector_out,
  input wire logic ecc_status_enable,
  input wire logic persistent_bits_lock,
  input wire logic [1:0] mode_bits
);
  // ==========================================
  // helper state and checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic acc;
  spg_cmd_e last_reg;
  logic err_reg;
  int bcnt_reg;
  assign acc = req_valid && !rsp.busy;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      last_reg <= SPG_CMD_NONE;
      err_reg <= 1'b0;
      bcnt_reg <= 0;
    end
    else if (acc)
    begin
      last_reg <= req.cmd;
      err_reg <= 1'b0;
      bcnt_reg <= 0;
    end
    else
    begin
      if ($rose(rsp.prog_err))
        err_reg <= 1'b1;
      if (rsp.busy)
        bcnt_reg <= bcnt_reg + 1;
    end
  a_fail_delay_held: assert property ($fell(rsp.busy) && last_reg == SPG_CMD_PW_UNLOCK
    && err_reg |-> bcnt_reg >= FAIL_CYCLES) else $error("failed unlock delay too short");
  a_good_unlock_fast: assert property ($fell(rsp.busy) && last_reg == SPG_CMD_PW_UNLOCK
    && !err_reg |-> bcnt_reg <= OP_CYCLES + 1 && persistent_bits_lock) else $error("good unlock");
  a_nv_locked_err: assert property (acc && !persistent_bits_lock &&
    (req.cmd == SPG_CMD_NV_PROG || req.cmd == SPG_CMD_NV_ERASE) |-> ##[1:3] rsp.prog_err)
    else $error("locked nv change gave no error");
  a_read_boot: assert property (read_protect && $past(read_protect)
    |-> rd_sector_out == 8'h00 && ecc_status_enable) else $error("read not forced to boot");
  a_pw_hidden: assert property (acc && req.cmd == SPG_CMD_PW_READ
    && mode_bits == SPG_MODE_PASSWORD |=> (!rsp.rd_valid) [*5]) else $error("password read");
  a_swr_lock_kept: assert property (acc && req.cmd == SPG_CMD_SW_RESET
    |=> $stable(persistent_bits_lock) [*4]) else $error("soft reset moved lock");
  a_pw_hwrst_lock: assert property ($fell(hw_reset_n) && mode_bits == SPG_MODE_PASSWORD
    |-> ##[1:6] !persistent_bits_lock) else $error("lock not cleared by hw reset");
  a_ps_hwrst_lock: assert property ($fell(hw_reset_n) && mode_bits != SPG_MODE_PASSWORD
    |-> ##[1:6] persistent_bits_lock) else $error("lock not set by hw reset");
  a_mode_fixed: assert property (mode_bits != SPG_MODE_NONE
    |=> mode_bits == $past(mode_bits)) else $error("mode bits changed");
  c_unlock: cover property (acc && req.cmd == SPG_CMD_PW_UNLOCK);
  c_fail: cover property ($fell(rsp.busy) && err_reg);
  c_clear: cover property (acc && req.cmd == SPG_CMD_LOCK_CLEAR);
endmodule : spg_guard_monitor

// [spg_host_model.sv]
`timescale 1ns/1ns
module spg_host_model
  import spg_pkg::*;
(
  // clock and command from bench
  input wire logic clk,
  input wire logic go,
  input wire spg_req_s cmd_in,
  // toward the guard
  output logic req_valid,
  output spg_req_s req,
  output logic sck
);
  // ==========================================
  // framed serial clock, then one strobe
  int n = 0;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
    sck = 1'b0;
  end
  always @(negedge clk)
  begin
    req_valid <= (n == 32);
    if (n == 32)
      req <= cmd_in;
    if (go && n == 0)
      n <= 1;
    else if (n > 0 && n < 32)
    begin
      n <= n + 1;
      if (n % 4 == 0)
        sck <= ~sck;
    end
    else if (n == 32)
    begin
      n <= 0;
      sck <= 1'b0;
    end
  end
endmodule : spg_host_model

// [spg_pkg.sv]
package spg_pkg;
  // protection mode selection bits [2:1] of the protection config register
  localparam logic [1:0] SPG_MODE_NONE = 2'h3;
  localparam logic [1:0] SPG_MODE_PERSIST = 2'h2;
  localparam logic [1:0] SPG_MODE_PASSWORD = 2'h1;
  localparam logic [1:0] SPG_MODE_ILLEGAL = 2'h0;
  localparam int SPG_PW_W = 64;
  localparam logic [63:0] SPG_PW_INIT = 64'hFFFFFFFFFFFFFFFF;
  localparam int SPG_CLK_MHZ = 50;
  // anti-guessing delay after a failed unlock, nominal and tolerance in us
  localparam int SPG_FAIL_DELAY_US = 100;
  localparam int SPG_FAIL_TOL_US = 20;
  localparam int SPG_FAIL_CYCLES = (SPG_FAIL_DELAY_US - SPG_FAIL_TOL_US) * SPG_CLK_MHZ;
  localparam int SPG_OP_CYCLES = 4;
  localparam int SPG_CNT_W = 16;

  typedef enum logic [3:0] {
    SPG_CMD_NONE,
    SPG_CMD_NV_PROG,
    SPG_CMD_NV_ERASE,
    SPG_CMD_VOL_WRITE,
    SPG_CMD_LOCK_CLEAR,
    SPG_CMD_PW_UNLOCK,
    SPG_CMD_PW_PROG,
    SPG_CMD_PW_READ,
    SPG_CMD_MODE_PROG,
    SPG_CMD_SW_RESET
  } spg_cmd_e;

  typedef struct packed {
    spg_cmd_e cmd;
    logic [7:0] sector;
    logic value;
    logic [63:0] data;
  } spg_req_s;

  typedef struct packed {
    logic busy;
    logic prog_err;
    logic [63:0] rd_data;
    logic rd_valid;
  } spg_rsp_s;
endpackage : spg_pkg

// [spg_sector_guard.sv]
`timescale 1ns/1ns
module spg_sector_guard
  import spg_pkg::*;
#(
  parameter int SECTORS = 256,
  parameter int SEC_W = 8,
  parameter int FAIL_CYCLES = SPG_FAIL_CYCLES,
  parameter int OP_CYCLES = SPG_OP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // hardware reset pin, active low, asynchronous to clk
  input wire logic hw_reset_n,
  // serial clock from host, sampled only for activity
  input wire logic sck,
  // decoded command request, one-cycle strobe
  input wire logic req_valid,
  input wire spg_req_s req,
  // engine query of a sector and read address path
  input wire logic [SEC_W-1:0] query_sector,
  input wire logic [SEC_W-1:0] rd_sector_in,
  input wire logic read_protect,
  input wire logic clear_status,
  // answers
  output spg_rsp_s rsp,
  output logic query_protected,
  output logic [SECTORS-1:0] sector_protected,
  output logic [SEC_W-1:0] rd_sector_out,
  output logic ecc_status_enable,
  output logic persistent_bits_lock,
  output logic [1:0] mode_bits,
  output logic sck_seen
);
  typedef enum logic [1:0] {
    SPG_IDLE,
    SPG_BUSY_OP,
    SPG_BUSY_FAIL
  } spg_state_e;

  typedef struct packed {
    spg_state_e state;
    logic [SECTORS-1:0] nv_bits;
    logic [SECTORS-1:0] vol_bits;
    logic lock;
    logic [1:0] mode;
    logic [63:0] pw;
    logic busy;
    logic perr;
    logic [63:0] rd_data;
    logic rd_valid;
    logic [SPG_CNT_W-1:0] op_cnt;
    logic hw_prev;
    logic first;
    logic qprot;
    logic [SECTORS-1:0] prot;
    logic [SEC_W-1:0] rd_sec;
    logic ecc_en;
    logic sck_seen;
  } spg_st_s;

  spg_st_s st_reg;
  spg_st_s st_next;

  logic hw_n_sync;
  logic sck_sync;
  logic sck_rise;
  logic tmr_load;
  logic tmr_run;
  logic tmr_done;

  // =========================================================
  // pin synchronisers
  // =========================================================
  spg_edge_sync u_hw_sync (
    .clk(clk),
    .nrst(nrst),
    .din(hw_reset_n),
    .dout(hw_n_sync),
    .rise()
  );

  spg_edge_sync u_sck_sync (
    .clk(clk),
    .nrst(nrst),
    .din(sck),
    .dout(sck_sync),
    .rise(sck_rise)
  );

  // =========================================================
  // anti-guessing timer
  // =========================================================
  // count is reloaded at each failed unlock
  spg_delay_timer #(
    .CNT_W(SPG_CNT_W)
  ) u_fail_tmr (
    .clk(clk),
    .nrst(nrst),
    .load(tmr_load),
    .count(SPG_CNT_W'(FAIL_CYCLES)),
    .running(tmr_run),
    .done(tmr_done)
  );

  // =========================================================
  // helper functions
  // =========================================================
  function automatic logic [SECTORS-1:0] prot_map(input logic [SECTORS-1:0] nv,
    input logic [SECTORS-1:0] vol);
    // a sector is open only with both bits at 1
    return ~(nv & vol);
  endfunction : prot_map

  function automatic logic is_pw_mode(input logic [1:0] m);
    return m == SPG_MODE_PASSWORD;
  endfunction : is_pw_mode

  function automatic logic lock_after_reset(input logic [1:0] m);
    return !is_pw_mode(m);
  endfunction : lock_after_reset

  // synchronised hardware reset pin has just gone low
  logic hw_assert;
  // request taken only when idle and settled after reset
  logic accept;

  // =========================================================
  // next-state logic
  // =========================================================
  always_comb
  begin
    st_next = st_reg;
    tmr_load = 1'b0;
    st_next.rd_valid = 1'b0;
    st_next.hw_prev = hw_n_sync;
    hw_assert = st_reg.hw_prev & ~hw_n_sync;
    accept = req_valid && st_reg.state == SPG_IDLE && !hw_assert && !st_reg.first;
    // link activity only; commands arrive already decoded
    if (sck_sync)
      st_next.sck_seen = 1'b1;
    // a new error later in this process wins over the clear
    if (clear_status && !st_reg.busy)
      st_next.perr = 1'b0;

    if (st_reg.first)
    begin
      // power-on: mode bits decide the lock start value
      st_next.first = 1'b0;
      st_next.lock = lock_after_reset(st_reg.mode);
    end
    else if (hw_assert)
    begin
      st_next.vol_bits = '1;
      st_next.lock = lock_after_reset(st_reg.mode);
      st_next.state = SPG_IDLE;
      st_next.busy = 1'b0;
    end

    case (st_reg.state)
      SPG_IDLE:
      begin
        // commands are taken only here
        if (accept)
        begin
          case (req.cmd)
            SPG_CMD_NV_PROG, SPG_CMD_NV_ERASE:
            begin
              if (!st_reg.lock)
                st_next.perr = 1'b1;
              // program one bit to 0, erase all to 1
              else if (req.cmd == SPG_CMD_NV_PROG)
                st_next.nv_bits[req.sector] = 1'b0;
              else
                st_next.nv_bits = '1;
              st_next.busy = 1'b1;
              st_next.op_cnt = SPG_CNT_W'(OP_CYCLES);
              st_next.state = SPG_BUSY_OP;
            end
            SPG_CMD_VOL_WRITE:
              st_next.vol_bits[req.sector] = req.value;
            SPG_CMD_LOCK_CLEAR:
              st_next.lock = 1'b0;
            SPG_CMD_SW_RESET:
              st_next.vol_bits = '1;
            SPG_CMD_PW_UNLOCK:
              // only password mode lets this command raise the lock again
              if (is_pw_mode(st_reg.mode))
              begin
                st_next.busy = 1'b1;
                if (req.data == st_reg.pw)
                begin
                  st_next.lock = 1'b1;
                  st_next.op_cnt = SPG_CNT_W'(OP_CYCLES);
                  st_next.state = SPG_BUSY_OP;
                end
                else
                begin
                  st_next.perr = 1'b1;
                  tmr_load = 1'b1;
                  st_next.state = SPG_BUSY_FAIL;
                end
              end
            SPG_CMD_PW_PROG:
              if (!is_pw_mode(st_reg.mode))
                st_next.pw = st_reg.pw & req.data;
            SPG_CMD_PW_READ:
              if (!is_pw_mode(st_reg.mode))
              begin
                st_next.rd_data = st_reg.pw;
                st_next.rd_valid = 1'b1;
              end
            SPG_CMD_MODE_PROG:
            begin
              if (req.data[1:0] == SPG_MODE_ILLEGAL || st_reg.mode != SPG_MODE_NONE)
                st_next.perr = 1'b1;
              else
                st_next.mode = st_reg.mode & req.data[1:0];
              st_next.busy = 1'b1;
              st_next.op_cnt = SPG_CNT_W'(OP_CYCLES);
              st_next.state = SPG_BUSY_OP;
            end
            default:
            begin
            end
          endcase
        end
      end
      SPG_BUSY_OP:
      begin
        // embedded operation time
        if (st_reg.op_cnt <= SPG_CNT_W'(1))
        begin
          st_next.busy = 1'b0;
          st_next.state = SPG_IDLE;
        end
        else
          st_next.op_cnt = st_reg.op_cnt - SPG_CNT_W'(1);
      end
      SPG_BUSY_FAIL:
      begin
        if (tmr_done)
        begin
          st_next.busy = 1'b0;
          st_next.state = SPG_IDLE;
        end
      end
      default:
        st_next.state = SPG_IDLE;
    endcase
    // hardware reset overrides whatever the state machine chose
    if (hw_assert)
    begin
      st_next.state = SPG_IDLE;
      st_next.busy = 1'b0;
    end

    // map and query are registered on the same edge as the bits
    // protection map
    st_next.prot = prot_map(st_next.nv_bits, st_next.vol_bits);
    st_next.qprot = st_next.prot[query_sector];
    st_next.rd_sec = read_protect ? '0 : rd_sector_in;
    st_next.ecc_en = !st_next.prot[st_next.rd_sec] || read_protect;
  end

  // =========================================================
  // state register
  // =========================================================
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // power-on: cells erased, mode unselected, lock set now and re-decided from mode next edge
      st_reg <= '0;
      st_reg.state <= SPG_IDLE;
      st_reg.nv_bits <= '1;
      st_reg.vol_bits <= '1;
      st_reg.lock <= 1'b1;
      st_reg.mode <= SPG_MODE_NONE;
      st_reg.pw <= SPG_PW_INIT;
      // matches the synchroniser reset level, so no false reset edge
      st_reg.hw_prev <= 1'b0;
      st_reg.first <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // =========================================================
  // outputs
  // =========================================================
  // write-in-progress, program error and password read
  assign rsp.busy = st_reg.busy;
  assign rsp.prog_err = st_reg.perr;
  assign rsp.rd_data = st_reg.rd_data;
  assign rsp.rd_valid = st_reg.rd_valid;
  // protection view toward the program and erase engine
  assign query_protected = st_reg.qprot;
  assign sector_protected = st_reg.prot;
  assign rd_sector_out = st_reg.rd_sec;
  assign ecc_status_enable = st_reg.ecc_en;
  assign persistent_bits_lock = st_reg.lock;
  assign mode_bits = st_reg.mode;
  assign sck_seen = st_reg.sck_seen;
endmodule : spg_sector_guard

// [spg_sector_guard_tb.sv]
`timescale 1ns/1ns
module spg_sector_guard_tb;
  import spg_pkg::*;
  // ==========================================
  // bench
  localparam int FC = 20;
  logic clk = 0, nrst = 0, hw_reset_n = 1, go = 0, read_protect = 0, clear_status = 0;
  logic sck, req_valid, query_protected, ecc_status_enable, persistent_bits_lock, sck_seen, rdv;
  logic [7:0] query_sector = 0, rd_sector_in = 0, rd_sector_out, s;
  spg_req_s req, cmd_q = '0;
  spg_rsp_s rsp;
  logic [255:0] sector_protected, nv_m = '1, vol_m = '1;
  logic [1:0] mode_bits;
  logic [63:0] pw, rdd;
  int nb, i, seed = 32'hae5a, miscompares = 0, check_count = 0;
  always #10 clk = ~clk;
  spg_host_model u_host (.clk, .go, .cmd_in(cmd_q), .req_valid, .req, .sck);
  spg_sector_guard #(.FAIL_CYCLES(FC)) DUT (.clk, .nrst, .hw_reset_n, .sck, .req_valid, .req,
    .query_sector, .rd_sector_in, .read_protect, .clear_status, .rsp, .query_protected,
    .sector_protected, .rd_sector_out, .ecc_status_enable, .persistent_bits_lock, .mode_bits,
    .sck_seen);
  function automatic logic [255:0] emap();
    return ~(nv_m & vol_m);
  endfunction : emap
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic issue(input spg_cmd_e c, input logic [7:0] sc, input logic v,
    input logic [63:0] d);
    @(negedge clk);
    cmd_q <= '{c, sc, v, d};
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    rdv = 0;
    nb = 0;
    for (i = 0; i < 200 && !(i > 40 && rsp.busy === 1'b0); i++)
    begin
      @(posedge clk);
      #1;
      if (rsp.rd_valid === 1'b1)
        {rdv, rdd} = {1'b1, rsp.rd_data};
      if (rsp.busy === 1'b1)
        nb++;
    end
    if (i == 200)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : issue
  task automatic pulse(input logic hw);
    @(negedge clk);
    {hw_reset_n, clear_status} <= {!hw, !hw};
    repeat (6) @(negedge clk);
    {hw_reset_n, clear_status} <= 2'b10;
    repeat (6) @(negedge clk);
  endtask : pulse
  initial
  begin
    repeat (4) @(negedge clk);
    nrst <= 1'b1;
    repeat (3) @(negedge clk);
    chk(persistent_bits_lock, 1, "lock");
    chk(mode_bits, SPG_MODE_NONE, "mode");
    chk(sector_protected, emap(), "map");
    for (int k = 0; k < 7; k++)
    begin
      s = (k == 0) ? 8'hFF : 8'($random(seed));
      vol_m[s] = (k == 0) ? 1'b0 : 1'($random(seed));
      issue(SPG_CMD_VOL_WRITE, s, vol_m[s], '0);
      chk(sector_protected, emap(), "vol map");
      @(negedge clk);
      query_sector <= s;
      repeat (3) @(negedge clk);
      chk(query_protected, (emap() >> s) & 256'h1, "query");
    end
    nv_m[0] = 1'b0;
    issue(SPG_CMD_NV_PROG, 8'h00, 1'b0, '0);
    chk(sector_protected, emap(), "nv prog");
    chk(sck_seen, 1, "link clock seen");
    issue(SPG_CMD_SW_RESET, 8'h00, 1'b0, '0);
    vol_m = '1;
    chk(sector_protected, emap(), "soft reset map");
    chk(persistent_bits_lock, 1, "soft reset lock");
    issue(SPG_CMD_NV_ERASE, 8'h00, 1'b0, '0);
    nv_m = '1;
    chk(sector_protected, emap(), "nv erase");
    pw = {$random(seed), $random(seed)};
    issue(SPG_CMD_PW_PROG, 8'h00, 1'b0, pw);
    issue(SPG_CMD_PW_PROG, 8'h00, 1'b0, '1);
    chk(rsp.prog_err, 0, "pw prog err");
    issue(SPG_CMD_PW_READ, 8'h00, 1'b0, '0);
    chk({rdv, rdd}, {1'b1, pw}, "pw read");
    issue(SPG_CMD_LOCK_CLEAR, 8'h00, 1'b0, '0);
    chk(persistent_bits_lock, 0, "lock clear");
    issue(SPG_CMD_NV_PROG, 8'h05, 1'b0, '0);
    chk({rsp.prog_err, sector_protected}, {1'b1, emap()}, "nv refused");
    pulse(1'b0);
    vol_m[5] = 1'b0;
    issue(SPG_CMD_VOL_WRITE, 8'h05, 1'b0, '0);
    chk(sector_protected, emap(), "vol while locked");
    @(negedge clk);
    read_protect <= 1'b1;
    rd_sector_in <= 8'h33;
    repeat (3) @(negedge clk);
    chk({rd_sector_out, ecc_status_enable}, 9'h001, "boot read");
    read_protect <= 1'b0;
    pulse(1'b1);
    vol_m = '1;
    chk({persistent_bits_lock, sector_protected}, {1'b1, emap()}, "hw reset");
    for (int m = 0; m < 3; m++)
    begin
      issue(SPG_CMD_MODE_PROG, 8'h00, 1'b0, 64'(m));
      chk({rsp.prog_err, mode_bits}, (m == 1) ? 3'h1 : 3'h4 + 3'(m == 0 ? 3 : 1), "mode");
      pulse(1'b0);
    end
    issue(SPG_CMD_PW_READ, 8'h00, 1'b0, '0);
    chk(rdv, 0, "pw hidden");
    pulse(1'b1);
    chk(persistent_bits_lock, 0, "pw mode lock");
    issue(SPG_CMD_PW_UNLOCK, 8'h00, 1'b0, pw ^ 64'h8000000000000001);
    chk({rsp.prog_err, persistent_bits_lock, nb >= FC}, 3'h5, "bad unlock");
    pulse(1'b0);
    issue(SPG_CMD_PW_UNLOCK, 8'h00, 1'b0, pw);
    chk({persistent_bits_lock, nb <= 6}, 2'h3, "good unlock");
    nv_m[9] = 1'b0;
    issue(SPG_CMD_NV_PROG, 8'h09, 1'b0, '0);
    chk(sector_protected, emap(), "nv after unlock");
    report_and_stop();
  end
endmodule : spg_sector_guard_tb
bind spg_sector_guard spg_guard_monitor #(.SECTORS(SECTORS), .FAIL_CYCLES(FAIL_CYCLES),
  .OP_CYCLES(OP_CYCLES)) u_mon (.clk, .nrst, .hw_reset_n, .req_valid, .req, .read_protect,
  .rsp, .sector_protected, .rd_sector_out, .ecc_status_enable, .persistent_bits_lock, .mode_bits);
